// *** fcp_pkg.sv ***
`default_nettype none
package fcp_pkg;

	// Boot mode field of the captured mode pins
	localparam int MODE_W = 2;
	localparam logic [1:0] MODE_DUAL_EXT_FIRST = 2'h0;
	localparam logic [1:0] MODE_DUAL_INT_FIRST = 2'h1;
	localparam int MODE_SDM_BIT = 1;

	// Master fetch framing
	localparam int SKIP_BITS = 128;
	localparam logic [15:0] PREAMBLE = 16'hBDB3;
	localparam int PREAMBLE_W = 16;
	localparam int CRC_W = 16;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8005;

	// Timeout for the preamble hunt, in link clocks
	localparam int PRE_TIMEOUT_CLKS = 16384;

	// Serial clock divider: half period in core clocks
	localparam int CORE_CLK_NS = 50;
	localparam int SCLK_HALF_NS = 100;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CORE_CLK_NS - 1)
		/ CORE_CLK_NS;

	// Status carried from the fetch engine
	typedef struct packed {
		logic done;
		logic timeout;
		logic crc_bad;
	} fcp_fetch_stat_t;

	// Boot sources
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_EXT,
		SRC_INT
	} fcp_src_t;

endpackage
`default_nettype wire

// *** fcp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// Two-flop level synchroniser
module fcp_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Level in and out
	input wire logic d,
	output logic q
);

	logic meta_q;

	// First flop feeds only the second
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule
`default_nettype wire

// *** fcp_fetch.sv ***
`timescale 1ns/1ns
`default_nettype none
// Master flash fetch engine on the serial clock
module fcp_fetch
(
	// Link clock and reset
	input wire logic sclk,
	input wire logic rst_b,
	// Control, level held by the core for a whole fetch
	input wire logic run,
	// Serial data from flash
	input wire logic miso,
	// Payload length in bits, ahead of the crc word
	input wire logic [15:0] image_len,
	// Status levels back to the core
	output fcp_pkg::fcp_fetch_stat_t stat
);

	typedef enum logic [2:0] {
		F_IDLE,
		F_SKIP,
		F_HUNT,
		F_LOAD,
		F_CRC,
		F_END
	} fcp_fstate_t;

	fcp_fstate_t st_q;
	logic [15:0] cnt_q;
	logic [15:0] sh_q;
	logic [15:0] crc_q;
	logic [15:0] crc_rx_q;
	fcp_pkg::fcp_fetch_stat_t stat_q;

	// One serial bit of crc update
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? fcp_pkg::CRC_POLY : 16'h0000);
	endfunction

	wire [15:0] sh_next = {sh_q[14:0], miso};
	wire pre_hit = (sh_next == fcp_pkg::PREAMBLE);

	// Cleared whenever the core stops a fetch; the serial clock stands
	// still outside a fetch, so a synchronous clear could be missed,
	// and release always falls while that clock is idle
	wire clr_b = rst_b && run;

	// Fetch sequencer, bits sampled on rising serial clock
	always_ff @(posedge sclk or negedge clr_b)
	begin
		if (!clr_b)
		begin
			st_q <= F_IDLE;
			cnt_q <= 16'h0000;
			sh_q <= 16'h0000;
			crc_q <= fcp_pkg::CRC_INIT;
			crc_rx_q <= 16'h0000;
			stat_q <= '0;
		end
		else
		begin
			sh_q <= sh_next;
			cnt_q <= cnt_q + 16'h0001;
			unique case (st_q)
				F_IDLE:
				begin
					st_q <= F_SKIP;
					cnt_q <= 16'h0001;
					crc_q <= fcp_pkg::CRC_INIT;
				end
				F_SKIP:
				begin
					// Discard the leading bits
					if (cnt_q == 16'(fcp_pkg::SKIP_BITS))
					begin
						st_q <= F_HUNT;
						cnt_q <= 16'h0000;
					end
				end
				F_HUNT:
				begin
					if (pre_hit)
					begin
						st_q <= F_LOAD;
						cnt_q <= 16'h0000;
					end
					else if (cnt_q == 16'(fcp_pkg::PRE_TIMEOUT_CLKS - 1))
					begin
						st_q <= F_END;
						stat_q.timeout <= 1'b1;
					end
				end
				F_LOAD:
				begin
					crc_q <= crc_step(crc_q, miso);
					if (cnt_q == image_len - 16'h0001)
					begin
						st_q <= F_CRC;
						cnt_q <= 16'h0000;
					end
				end
				F_CRC:
				begin
					crc_rx_q <= sh_next;
					if (cnt_q == 16'(fcp_pkg::CRC_W - 1))
					begin
						st_q <= F_END;
						stat_q.crc_bad <= (sh_next != crc_q);
						stat_q.done <= (sh_next == crc_q);
					end
				end
				F_END:
				begin
					cnt_q <= cnt_q;
				end
				default:
				begin
					st_q <= F_IDLE;
				end
			endcase
		end
	end

	assign stat = stat_q;

endmodule
`default_nettype wire

// *** fcp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcp_top
(
	// Core clock and power-up reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// Mode pins and fuses
	input wire logic [1:0] CFG_MODE,
	input wire logic DONE_FUSE,
	input wire logic SECURITY_FUSE,
	input wire logic INT_FLASH_OK,
	input wire logic [15:0] IMAGE_BITS,
	// Init-ready open drain
	input wire logic INIT_READY_N_I,
	output logic INIT_READY_N_O,
	output logic INIT_READY_N_OE,
	// Program request and jtag activity
	input wire logic PROGRAM_REQUEST_N,
	input wire logic JTAG_ACTIVE,
	input wire logic JTAG_REFRESH,
	// Done open drain
	input wire logic DONE_I,
	output logic DONE_O,
	output logic DONE_OE,
	// Serial clock pin
	input wire logic CONFIG_SERIAL_CLOCK_I,
	output logic CONFIG_SERIAL_CLOCK_O,
	output logic CONFIG_SERIAL_CLOCK_OE,
	// Spi data pins and selects
	input wire logic SPI_DATA_A_I,
	output logic SPI_DATA_A_O,
	output logic SPI_DATA_A_OE,
	input wire logic SPI_DATA_B_I,
	output logic SPI_DATA_B_O,
	output logic SPI_DATA_B_OE,
	output logic MASTER_FLASH_SELECT_N,
	input wire logic SLAVE_SELECT_N,
	input wire logic SLAVE_MODE,
	output logic SLAVE_FRAME,
	// User io tristate
	input wire logic IO_TRISTATE_N,
	output logic USER_IO_ENABLE,
	// Background access
	input wire logic BG_READ_REQ,
	output logic BG_READ_GRANT,
	output logic BG_READ_REFUSED,
	// Status
	output logic [1:0] MODE_LATCHED,
	output logic SELF_DOWNLOAD_MODE,
	output logic CFG_TIMEOUT,
	output logic CFG_CRC_BAD,
	output logic CFG_FAILED,
	output logic SECURITY_LATCH
);

	typedef enum logic [2:0] {
		S_RESET,
		S_INIT,
		S_PRIMARY,
		S_FAIL_PULSE,
		S_SECONDARY,
		S_WAKE,
		S_HALT
	} fcp_state_t;

	fcp_state_t st_q;
	fcp_pkg::fcp_src_t src_q;
	logic [1:0] mode_q;
	logic sec_q;
	logic sec_taken_q;
	logic jtag_used_q;
	logic prog_s;
	logic prog_q;
	logic init_s;
	logic init_prev_q;
	logic sclk_q;
	logic [3:0] div_q;
	logic run_q;
	logic tmo_q;
	logic crc_q;
	logic fail_q;
	logic [1:0] fails_q;
	logic jtag_s;
	logic tristate_s;
	logic sel_s;
	logic slave_s;
	fcp_pkg::fcp_fetch_stat_t fstat;
	logic fdone_s;
	logic ftmo_s;
	logic fcrc_s;

	// Synchronise pins and fetch status into the core domain
	fcp_sync u_sync_prog (.clk(CORE_CLK), .rst_b(RST_B),
		.d(PROGRAM_REQUEST_N), .q(prog_s));
	fcp_sync u_sync_init (.clk(CORE_CLK), .rst_b(RST_B),
		.d(INIT_READY_N_I), .q(init_s));
	fcp_sync u_sync_jtag (.clk(CORE_CLK), .rst_b(RST_B),
		.d(JTAG_ACTIVE), .q(jtag_s));
	fcp_sync u_sync_toe (.clk(CORE_CLK), .rst_b(RST_B),
		.d(IO_TRISTATE_N), .q(tristate_s));
	fcp_sync u_sync_sel (.clk(CORE_CLK), .rst_b(RST_B),
		.d(SLAVE_SELECT_N), .q(sel_s));
	fcp_sync u_sync_slv (.clk(CORE_CLK), .rst_b(RST_B),
		.d(SLAVE_MODE), .q(slave_s));
	fcp_sync u_sync_fd (.clk(CORE_CLK), .rst_b(RST_B),
		.d(fstat.done), .q(fdone_s));
	fcp_sync u_sync_ft (.clk(CORE_CLK), .rst_b(RST_B),
		.d(fstat.timeout), .q(ftmo_s));
	fcp_sync u_sync_fc (.clk(CORE_CLK), .rst_b(RST_B),
		.d(fstat.crc_bad), .q(fcrc_s));

	// Fetch engine on the serial clock as seen on the pin
	fcp_fetch u_fetch (
		.sclk(CONFIG_SERIAL_CLOCK_I),
		.rst_b(RST_B),
		.run(run_q),
		.miso(SPI_DATA_B_I),
		.image_len(IMAGE_BITS),
		.stat(fstat)
	);

	// Decode of events and mode
	wire init_rise = init_s && !init_prev_q;
	wire prog_fall = prog_q && !prog_s;
	wire prog_start = prog_fall && !jtag_used_q;
	wire restart = prog_start || JTAG_REFRESH;
	wire self_download_mode = mode_q[fcp_pkg::MODE_SDM_BIT];
	wire ext_first = (mode_q == fcp_pkg::MODE_DUAL_EXT_FIRST);
	wire ext_active = (src_q == fcp_pkg::SRC_EXT);
	wire fetch_fail = ftmo_s || fcrc_s;
	wire int_ok = DONE_FUSE && INT_FLASH_OK;
	wire master_on = ext_active && run_q && !slave_s;
	wire slave_on = slave_s && !sel_s;

	// Pick source for an attempt, per boot mode
	function automatic fcp_pkg::fcp_src_t pick_src(input logic [1:0] m,
		input logic second);
		if (m[fcp_pkg::MODE_SDM_BIT])
			pick_src = second ? fcp_pkg::SRC_NONE : fcp_pkg::SRC_INT;
		else if ((m == fcp_pkg::MODE_DUAL_EXT_FIRST) ^ second)
			pick_src = fcp_pkg::SRC_EXT;
		else
			pick_src = fcp_pkg::SRC_INT;
	endfunction

	// Edge history and jtag sticky latch
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			init_prev_q <= 1'b0;
			prog_q <= 1'b0; // Same as synchroniser reset: no false fall
			jtag_used_q <= 1'b0;
		end
		else
		begin
			init_prev_q <= init_s;
			prog_q <= prog_s;
			if (jtag_s)
				jtag_used_q <= 1'b1;
		end
	end

	// Mode capture on init rising edge
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
			mode_q <= 2'h0;
		else if (init_rise)
			mode_q <= CFG_MODE;
	end

	// Security latch, loaded once after power-up only
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			sec_q <= 1'b0;
			sec_taken_q <= 1'b0;
		end
		else if (!sec_taken_q)
		begin
			sec_q <= SECURITY_FUSE;
			sec_taken_q <= 1'b1;
		end
	end

	// Serial clock divider, runs only while fetching
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			div_q <= 4'h0;
			sclk_q <= 1'b0;
		end
		else if (!master_on)
		begin
			div_q <= 4'h0;
			sclk_q <= 1'b0;
		end
		else if (div_q == 4'(fcp_pkg::SCLK_HALF_CYC - 1))
		begin
			div_q <= 4'h0;
			sclk_q <= !sclk_q;
		end
		else
			div_q <= div_q + 4'h1;
	end

	// Configuration sequencer
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st_q <= S_RESET;
			src_q <= fcp_pkg::SRC_NONE;
			run_q <= 1'b0;
			tmo_q <= 1'b0;
			crc_q <= 1'b0;
			fail_q <= 1'b0;
			fails_q <= 2'h0;
		end
		else if (restart && st_q != S_RESET)
		begin
			st_q <= S_RESET;
			run_q <= 1'b0;
			src_q <= fcp_pkg::SRC_NONE;
		end
		else
		begin
			unique case (st_q)
				S_RESET:
				begin
					fails_q <= 2'h0;
					fail_q <= 1'b0;
					if (prog_s)
						st_q <= S_INIT;
				end
				S_INIT:
				begin
					if (init_rise)
					begin
						st_q <= S_PRIMARY;
						src_q <= pick_src(CFG_MODE, 1'b0);
						run_q <= (pick_src(CFG_MODE, 1'b0) ==
							fcp_pkg::SRC_EXT);
						tmo_q <= 1'b0;
						crc_q <= 1'b0;
					end
				end
				S_PRIMARY, S_SECONDARY:
				begin
					if (ext_active && fdone_s)
					begin
						st_q <= S_WAKE;
						run_q <= 1'b0;
					end
					else if (ext_active && fetch_fail)
					begin
						tmo_q <= ftmo_s;
						crc_q <= fcrc_s;
						run_q <= 1'b0;
						fails_q <= fails_q + 2'h1;
						st_q <= (st_q == S_PRIMARY && !self_download_mode) ?
							S_FAIL_PULSE : S_HALT;
					end
					else if (!ext_active)
					begin
						if (int_ok)
							st_q <= S_WAKE;
						else if (st_q == S_PRIMARY && !self_download_mode)
							st_q <= S_FAIL_PULSE;
						else
							st_q <= S_HALT;
					end
				end
				S_FAIL_PULSE:
				begin
					// Init pulses low, then the other source runs
					st_q <= S_SECONDARY;
					src_q <= pick_src(mode_q, 1'b1);
					run_q <= ext_first ? 1'b0 : 1'b1;
				end
				S_WAKE:
				begin
					run_q <= 1'b0;
				end
				S_HALT:
				begin
					fail_q <= 1'b1;
					run_q <= 1'b0;
				end
				default:
				begin
					st_q <= S_RESET;
				end
			endcase
		end
	end

	// Open drain and direction control
	assign INIT_READY_N_O = 1'b0;
	assign INIT_READY_N_OE = (st_q == S_RESET) || (st_q == S_FAIL_PULSE)
		|| (st_q == S_HALT);
	assign DONE_O = 1'b0;
	assign DONE_OE = (st_q != S_WAKE);
	assign CONFIG_SERIAL_CLOCK_O = sclk_q;
	assign CONFIG_SERIAL_CLOCK_OE = master_on;
	assign SPI_DATA_A_O = 1'b0; // Read command bits idle low
	assign SPI_DATA_A_OE = master_on;
	assign SPI_DATA_B_O = SPI_DATA_A_I && slave_on;
	assign SPI_DATA_B_OE = slave_on;
	assign MASTER_FLASH_SELECT_N = !master_on;
	assign SLAVE_FRAME = slave_on;
	assign USER_IO_ENABLE = tristate_s && (st_q == S_WAKE);

	// Background readback gated by the security latch
	assign BG_READ_GRANT = BG_READ_REQ && !sec_q;
	assign BG_READ_REFUSED = BG_READ_REQ && sec_q;

	// Status outputs
	assign MODE_LATCHED = mode_q;
	assign SELF_DOWNLOAD_MODE = self_download_mode;
	assign CFG_TIMEOUT = tmo_q;
	assign CFG_CRC_BAD = crc_q;
	assign CFG_FAILED = fail_q;
	assign SECURITY_LATCH = sec_q;

endmodule
`default_nettype wire

// *** fcp_top_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
// Pin level checks for the configuration controller
module fcp_top_sva
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// Watched pins
	input wire logic IO_TRISTATE_N,
	input wire logic USER_IO_ENABLE,
	input wire logic BG_READ_REQ,
	input wire logic BG_READ_GRANT,
	input wire logic BG_READ_REFUSED,
	input wire logic SECURITY_LATCH,
	input wire logic [1:0] MODE_LATCHED,
	input wire logic INIT_READY_N_I,
	input wire logic INIT_READY_N_O,
	input wire logic INIT_READY_N_OE,
	input wire logic DONE_O,
	input wire logic DONE_OE,
	input wire logic CFG_FAILED,
	input wire logic MASTER_FLASH_SELECT_N,
	input wire logic CONFIG_SERIAL_CLOCK_OE,
	input wire logic SPI_DATA_B_OE
);
	logic [1:0] age_q;
	logic [1:0] age_d;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	// Edges since reset release, saturating at three
	assign age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
			age_q <= 2'h0;
		else
			age_q <= age_d;
	end
	property p_open_drain;
		!INIT_READY_N_O && !DONE_O;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open drain pin driven high");
	property p_io_off;
		!IO_TRISTATE_N [*3] |-> !USER_IO_ENABLE;
	endproperty
	a_io_off: assert property (p_io_off)
		else $error("user io enabled while tristated");
	property p_bg_refuse;
		SECURITY_LATCH && BG_READ_REQ |->
			BG_READ_REFUSED && !BG_READ_GRANT;
	endproperty
	a_bg_refuse: assert property (p_bg_refuse)
		else $error("readback not refused");
	property p_sec_keep;
		age_q == 2'h3 |=> $stable(SECURITY_LATCH);
	endproperty
	a_sec_keep: assert property (p_sec_keep)
		else $error("security latch changed after power-up");
	property p_mode_cap;
		$changed(MODE_LATCHED) && MODE_LATCHED != 2'h0 |-> INIT_READY_N_I;
	endproperty
	a_mode_cap: assert property (p_mode_cap)
		else $error("mode captured while init low");
	property p_b_in;
		!MASTER_FLASH_SELECT_N |-> !SPI_DATA_B_OE;
	endproperty
	a_b_in: assert property (p_b_in)
		else $error("data b driven in master fetch");
	property p_config_serial_clock;
		CONFIG_SERIAL_CLOCK_OE |-> !MASTER_FLASH_SELECT_N;
	endproperty
	a_config_serial_clock: assert property (p_config_serial_clock)
		else $error("serial clock driven without flash select");
	property p_fail_hold;
		CFG_FAILED [*2] |-> INIT_READY_N_OE && DONE_OE;
	endproperty
	a_fail_hold: assert property (p_fail_hold)
		else $error("init or done released after failure");
endmodule
bind fcp_top fcp_top_sva i_fcp_top_sva
(
	.CORE_CLK, .RST_B, .IO_TRISTATE_N, .USER_IO_ENABLE, .BG_READ_REQ,
	.BG_READ_GRANT, .BG_READ_REFUSED, .SECURITY_LATCH, .MODE_LATCHED,
	.INIT_READY_N_I, .INIT_READY_N_O, .INIT_READY_N_OE, .DONE_O, .DONE_OE,
	.CFG_FAILED, .MASTER_FLASH_SELECT_N, .CONFIG_SERIAL_CLOCK_OE,
	.SPI_DATA_B_OE
);
`default_nettype wire

// *** fcp_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Serial flash holding the golden image; scen 0 good, 1 bad crc, 2 blank
module fcp_flash_model #(parameter int PAY = 64)
(
	// Link side
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [1:0] scen,
	output logic miso
);
	int idx;
	logic [15:0] crc_q;
	// Payload pattern
	function automatic logic pay_bit(input int k);
		return k[0] ^ k[3];
	endfunction
	// Crc over the payload, msb first
	function automatic logic [15:0] calc();
		logic [15:0] c;
		logic fb;
		c = fcp_pkg::CRC_INIT;
		for (int k = 0; k < PAY; k++)
		begin
			fb = c[15] ^ pay_bit(k);
			c = {c[14:0], 1'b0} ^ (fb ? fcp_pkg::CRC_POLY : 16'h0000);
		end
		return c;
	endfunction
	// Image stream; the skipped head carries decoy preambles
	function automatic logic bit_at(input int i);
		if (scen == 2'h2)
			return 1'b1;
		if (i < 128)
			return fcp_pkg::PREAMBLE[15 - i % 16];
		if (i < 144)
			return fcp_pkg::PREAMBLE[143 - i];
		if (i < 144 + PAY)
			return pay_bit(i - 144);
		if (i < 160 + PAY)
			return crc_q[159 + PAY - i] ^ (scen == 2'h1);
		return 1'b0;
	endfunction
	initial crc_q = calc();
	// Shift out on falling edges while selected
	always @(negedge cs_n)
	begin
		idx = 0;
		miso = bit_at(0);
	end
	always @(negedge sclk)
	begin
		if (!cs_n)
		begin
			idx++;
			miso = bit_at(idx);
		end
	end
	// Released line shows no stale data
	always @(posedge cs_n) miso = ~miso;
endmodule
`default_nettype wire

// *** fcp_top_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcp_top_tb_top;
	logic clk, link_clk, rst_b, oe_l, fuse_ok, sec, prog_n, jtag, refresh;
	logic tri_n, slv, ssel_n, fetched, a_ok, bg_req;
	logic [1:0] mode, scen, mode_l;
	logic init_o, init_oe, done_o, done_oe, sclk_o, sclk_oe, a_o, a_oe, b_o;
	logic b_oe, fsel_n, frame, io_en, grant, refused, self_download_mode, tmo, crc_bad;
	logic failed, sec_l, miso;
	wire logic sclk_pin;
	int miscompares, checked;
	// Clocks; link clock gated in only while the device runs a fetch
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		link_clk = 0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	always @(negedge link_clk) oe_l <= sclk_oe;
	assign sclk_pin = oe_l & link_clk;
	// Pin directions seen during master fetch
	always @(negedge clk)
	begin
		if (fsel_n === 1'b0)
		begin
			fetched = fetched | sclk_o;
			a_ok = a_ok & a_oe & ~b_oe;
		end
	end
	fcp_top i_fcp_top (.CORE_CLK(clk), .RST_B(rst_b), .CFG_MODE(mode),
		.DONE_FUSE(fuse_ok), .SECURITY_FUSE(sec), .INT_FLASH_OK(fuse_ok),
		.IMAGE_BITS(16'h0040), .INIT_READY_N_I(init_oe ? init_o : 1'b1),
		.INIT_READY_N_O(init_o), .INIT_READY_N_OE(init_oe),
		.PROGRAM_REQUEST_N(prog_n), .JTAG_ACTIVE(jtag),
		.JTAG_REFRESH(refresh), .DONE_I(done_oe ? done_o : 1'b1),
		.DONE_O(done_o), .DONE_OE(done_oe), .CONFIG_SERIAL_CLOCK_I(sclk_pin),
		.CONFIG_SERIAL_CLOCK_O(sclk_o), .CONFIG_SERIAL_CLOCK_OE(sclk_oe),
		.SPI_DATA_A_I(a_oe ? a_o : 1'b1), .SPI_DATA_A_O(a_o),
		.SPI_DATA_A_OE(a_oe), .SPI_DATA_B_I(miso), .SPI_DATA_B_O(b_o),
		.SPI_DATA_B_OE(b_oe), .MASTER_FLASH_SELECT_N(fsel_n),
		.SLAVE_SELECT_N(ssel_n), .SLAVE_MODE(slv), .SLAVE_FRAME(frame),
		.IO_TRISTATE_N(tri_n), .USER_IO_ENABLE(io_en), .BG_READ_REQ(bg_req),
		.BG_READ_GRANT(grant), .BG_READ_REFUSED(refused),
		.MODE_LATCHED(mode_l), .SELF_DOWNLOAD_MODE(self_download_mode), .CFG_TIMEOUT(tmo),
		.CFG_CRC_BAD(crc_bad), .CFG_FAILED(failed), .SECURITY_LATCH(sec_l));
	fcp_flash_model #(.PAY(64)) i_fcp_flash_model (.sclk(sclk_pin),
		.cs_n(fsel_n), .scen(scen), .miso(miso));
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s exp %b got %b", what, exp, got);
		end
	endtask
	task chk_mode(input string what, input logic [1:0] exp,
		input logic [1:0] got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	// Restart by program pin or refresh, then wait for wake or failure
	task boot(input logic [1:0] m, input logic ok, input logic [1:0] s,
		input logic r);
		int n;
		mode = m;
		fuse_ok = ok;
		scen = s;
		fetched = 1'b0;
		a_ok = 1'b1;
		refresh = r;
		prog_n = r;
		cyc(1);
		refresh = 1'b0;
		cyc(3);
		prog_n = 1'b1;
		for (n = 0; n < 200 && (!done_oe || failed); n++) cyc(1);
		for (n = 0; n < 40000 && done_oe && !failed; n++) cyc(1);
		cyc(4);
	endtask
	task wrap_up();
		$display("checks %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (70000) @(posedge clk);
		miscompares++;
		$display("wrong value watchdog exp 0 got 1");
		wrap_up();
	end
	initial
	begin
		int n;
		{mode, fuse_ok, scen, sec, prog_n, jtag, refresh} = 9'h14C;
		{tri_n, slv, ssel_n, rst_b, fetched, a_ok, bg_req} = 7'h53;
		cyc(3);
		chk_bit("init_oe", 1, init_oe);
		chk_bit("done_oe", 1, done_oe);
		cyc(17);
		rst_b = 1;
		for (n = 0; n < 2000 && done_oe; n++) cyc(1);
		cyc(4);
		chk_bit("sec_latch", 1, sec_l);
		chk_bit("refused", 1, refused);
		chk_bit("grant", 0, grant);
		chk_mode("mode", 2'h2, mode_l);
		chk_bit("sdm", 1, self_download_mode);
		chk_bit("io_en", 1, io_en);
		tri_n = 0;
		cyc(4);
		chk_bit("io_en", 0, io_en);
		tri_n = 1;
		sec = 0;
		$display("test power_up done");
		boot(2'h0, 0, 2'h0, 0);
		chk_bit("fetched", 1, fetched);
		chk_bit("pin_dir", 1, a_ok);
		chk_bit("done_oe", 0, done_oe);
		chk_bit("sec_latch", 1, sec_l);
		boot(2'h0, 1, 2'h1, 0);
		chk_bit("crc_bad", 1, crc_bad);
		chk_bit("done_oe", 0, done_oe);
		boot(2'h1, 0, 2'h0, 0);
		chk_bit("fetched", 1, fetched);
		chk_bit("done_oe", 0, done_oe);
		boot(2'h1, 0, 2'h2, 0);
		chk_bit("timeout", 1, tmo);
		chk_bit("failed", 1, failed);
		cyc(50);
		chk_bit("init_oe", 1, init_oe);
		boot(2'h3, 0, 2'h0, 0);
		chk_bit("fetched", 0, fetched);
		chk_bit("failed", 1, failed);
		$display("test boot_order done");
		slv = 1;
		ssel_n = 0;
		cyc(5);
		chk_bit("frame", 1, frame);
		chk_bit("b_oe", 1, b_oe);
		chk_bit("a_oe", 0, a_oe);
		ssel_n = 1;
		cyc(5);
		chk_bit("frame", 0, frame);
		slv = 0;
		$display("test slave done");
		boot(2'h2, 1, 2'h0, 0);
		jtag = 1;
		cyc(2);
		jtag = 0;
		prog_n = 0;
		cyc(4);
		prog_n = 1;
		cyc(20);
		chk_bit("done_oe", 0, done_oe);
		boot(2'h0, 1, 2'h0, 1);
		chk_bit("fetched", 1, fetched);
		chk_bit("done_oe", 0, done_oe);
		$display("test jtag done");
		rst_b = 0;
		cyc(20);
		rst_b = 1;
		for (n = 0; n < 2000 && done_oe; n++) cyc(1);
		chk_bit("sec_latch", 0, sec_l);
		chk_bit("grant", 1, grant);
		bg_req = 0;
		cyc(1);
		chk_bit("grant", 0, grant);
		chk_bit("refused", 0, refused);
		$display("test second_reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
